// file: shared/tap_orient_pkg.sv
/*
  Constants for the tap and orientation interrupt configuration block.
  Assumes a single 250 MHz clock and a same-clock register write port.
*/
package tap_orient_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] TAP_THR_ADDR = 8'h64;
  localparam logic [7:0] ORIENT_ADDR = 8'h65;
  localparam logic [4:0] TAP_THR_RST = 5'h0A;
  localparam logic [7:0] ORIENT_RST = 8'h18;
  localparam int TAP_THR_W = 5;
  localparam int HYST_LSB = 4;
  localparam int BLOCK_LSB = 2;
  localparam int MODE_LSB = 0;
  // ==========================================================
  // Timing
  localparam int CLK_KHZ = 250000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
  localparam logic [9:0] QUIET_LONG_MS = 10'h01E;
  localparam logic [9:0] QUIET_SHORT_MS = 10'h014;
  localparam logic [9:0] SHOCK_SHORT_MS = 10'h032;
  localparam logic [9:0] SHOCK_LONG_MS = 10'h04B;
  localparam logic [9:0] DTAP_WIN_MS [0:7] = '{10'h032, 10'h064, 10'h096, 10'h0C8,
                                               10'h0FA, 10'h177, 10'h1F4, 10'h2BC};
  localparam logic [6:0] ORIENT_STABLE_MS = 7'h64;
  // ==========================================================
  // Acceleration limits in mg, hysteresis in half mg per code
  localparam logic [15:0] HIGH_G_MG = 16'h05DC;
  localparam logic [15:0] SLOPE_LO_MG = 16'h00C8;
  localparam logic [15:0] SLOPE_HI_MG = 16'h0190;
  localparam logic [6:0] HYST_HALF_MG = 7'h7D;
  // ==========================================================
  // Modes and states
  localparam logic [1:0] BLK_NONE = 2'h0;
  localparam logic [1:0] BLK_HIGH_G = 2'h1;
  localparam logic [1:0] BLK_SLOPE_LO = 2'h2;
  localparam logic [1:0] BLK_SLOPE_HI = 2'h3;
  typedef enum logic [1:0] {TAP_IDLE, TAP_SHOCK, TAP_QUIET, TAP_WINDOW} tap_state_e;
endpackage

// file: rtl/orient_block.sv
/*
  Orientation blocking and change detection.
  Assumes samples, slopes and the theta condition arrive on clk.
*/
`timescale 1ns/1ns
module orient_block (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ms_tick,
  // Settings
  input wire logic [1:0] block_mode,
  // Samples
  input wire logic sample_valid,
  input wire logic signed [15:0] acc_x,
  input wire logic signed [15:0] acc_y,
  input wire logic signed [15:0] acc_z,
  input wire logic [15:0] slope_x,
  input wire logic [15:0] slope_y,
  input wire logic [15:0] slope_z,
  input wire logic theta_block,
  input wire logic [2:0] orient_code,
  // Results
  output logic orient_blocked,
  output logic orient_evt
);
  logic [6:0] stable_ms_reg;
  logic [2:0] last_code_reg;
  logic [2:0] reported_reg;
  logic high_g;
  logic slope_lo;
  logic slope_hi;
  logic block_next;
  logic code_change;

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // ==========================================================
  // Blocking conditions
  assign high_g = mag(acc_x) > tap_orient_pkg::HIGH_G_MG || mag(acc_y) > tap_orient_pkg::HIGH_G_MG
                  || mag(acc_z) > tap_orient_pkg::HIGH_G_MG;
  assign slope_lo = slope_x > tap_orient_pkg::SLOPE_LO_MG || slope_y > tap_orient_pkg::SLOPE_LO_MG
                    || slope_z > tap_orient_pkg::SLOPE_LO_MG;
  assign slope_hi = slope_x > tap_orient_pkg::SLOPE_HI_MG || slope_y > tap_orient_pkg::SLOPE_HI_MG
                    || slope_z > tap_orient_pkg::SLOPE_HI_MG;

  // A sample carrying a new raw code is not yet stable, whatever the timer says
  assign code_change = sample_valid && orient_code != last_code_reg;

  // Mode decides which conditions count
  always_comb begin
    case (block_mode)
      tap_orient_pkg::BLK_NONE: block_next = 1'b0;
      tap_orient_pkg::BLK_HIGH_G: block_next = theta_block | high_g;
      tap_orient_pkg::BLK_SLOPE_LO: block_next = theta_block | slope_lo | high_g;
      tap_orient_pkg::BLK_SLOPE_HI: block_next = theta_block | slope_hi | high_g | code_change
                                      | (stable_ms_reg < tap_orient_pkg::ORIENT_STABLE_MS);
      default: block_next = 1'b0;
    endcase
  end

  // Time since the raw orientation last changed, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      stable_ms_reg <= 7'h00;
      last_code_reg <= 3'h0;
    end else if (sample_valid && orient_code != last_code_reg) begin
      stable_ms_reg <= 7'h00;
      last_code_reg <= orient_code;
    end else if (ms_tick && stable_ms_reg < tap_orient_pkg::ORIENT_STABLE_MS) begin
      stable_ms_reg <= stable_ms_reg + 7'h01;
    end
  end

  // Report a new orientation only while unblocked
  always_ff @(posedge clk) begin
    if (rst) begin
      orient_blocked <= 1'b0;
      orient_evt <= 1'b0;
      reported_reg <= 3'h0;
    end else begin
      orient_blocked <= block_next;
      orient_evt <= 1'b0;
      if (sample_valid && !block_next && orient_code != reported_reg) begin
        orient_evt <= 1'b1;
        reported_reg <= orient_code;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_blk_high_g;
    @(posedge clk) disable iff (rst)
    (block_mode == tap_orient_pkg::BLK_HIGH_G && mag(acc_x) > tap_orient_pkg::HIGH_G_MG)
      |=> orient_blocked;
  endproperty
  a_blk_high_g: assert property (p_blk_high_g) else $error("high g not blocked");

  property p_blk_slope;
    @(posedge clk) disable iff (rst)
    (block_mode == tap_orient_pkg::BLK_SLOPE_LO && slope_y > tap_orient_pkg::SLOPE_LO_MG)
      |=> orient_blocked;
  endproperty
  a_blk_slope: assert property (p_blk_slope) else $error("slope not blocked");

  property p_blk_stable;
    @(posedge clk) disable iff (rst)
    (orient_evt && $past(block_mode) == tap_orient_pkg::BLK_SLOPE_HI)
      |-> $past(stable_ms_reg) >= tap_orient_pkg::ORIENT_STABLE_MS;
  endproperty
  a_blk_stable: assert property (p_blk_stable) else $error("unstable orientation passed");

  property p_blk_none;
    @(posedge clk) disable iff (rst)
    (block_mode == tap_orient_pkg::BLK_NONE) |=> !orient_blocked;
  endproperty
  a_blk_none: assert property (p_blk_none) else $error("blocked with no blocking");

  c_orient_evt: cover property (@(posedge clk) disable iff (rst) orient_evt);
endmodule // orient_block

// file: rtl/tap_orient_interrupt_config.sv
/*
  Tap detection timing, tap threshold scaling, low-power gating and the
  orientation configuration register. Assumes a same-clock register write
  port and same-clock sample inputs from the sensor datapath.
*/
`timescale 1ns/1ns
// Summary of operation
// - Quiet select: 30 ms clear, 20 set
// - Shock select: 50 ms clear, 75 set
// - Double-tap window code picks 50 to 700 ms
// - Pre-filtered tap data forbids low-power mode
// - Tap threshold is low four code bits times range step
// - Zero threshold code counts as one half
// - Orientation hysteresis 62.5 mg per code
// - Blocking 00 none, 01 theta or high-g
// - Blocking 10 adds slope above 0.2 g
// - Blocking 11 slope 0.4 g, stable 100 ms
// - Mode field selects orientation switching thresholds
module tap_orient_interrupt_config #(
  parameter int TICK_CYCLES = tap_orient_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Tap timing and data source settings
  input wire logic tap_quiet_sel,
  input wire logic tap_shock_sel,
  input wire logic [2:0] tap_dur_sel,
  input wire logic [1:0] acc_range,
  input wire logic tap_prefilt_sel,
  input wire logic lp_request,
  // Samples
  input wire logic sample_valid,
  input wire logic [11:0] tap_slope,
  input wire logic signed [15:0] acc_x,
  input wire logic signed [15:0] acc_y,
  input wire logic signed [15:0] acc_z,
  input wire logic [15:0] slope_x,
  input wire logic [15:0] slope_y,
  input wire logic [15:0] slope_z,
  input wire logic theta_block,
  input wire logic [2:0] orient_code,
  // Results
  output logic single_tap_evt,
  output logic double_tap_evt,
  output logic [7:0] tap_thr_eff,
  output logic low_power_en,
  output logic [10:0] orient_hyst_half_mg,
  output logic [1:0] orient_mode_sel,
  output logic orient_blocked,
  output logic orient_evt
);
  tap_orient_pkg::tap_state_e state_reg;
  logic [4:0] tap_threshold_reg;
  logic [7:0] orient_cfg_reg;
  logic [31:0] div_cnt_reg;
  logic ms_tick;
  logic [9:0] elapsed_ms_reg;
  logic above_prev_reg;
  logic above;
  logic shock_rise;
  logic [9:0] shock_ms;
  logic [9:0] quiet_ms;
  logic [9:0] win_ms;
  logic [7:0] thr_next;

  // ==========================================================
  // Configuration registers
  // Reserved upper bits of the threshold byte are not stored and read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      tap_threshold_reg <= tap_orient_pkg::TAP_THR_RST;
      orient_cfg_reg <= tap_orient_pkg::ORIENT_RST;
    end else if (reg_wr) begin
      if (reg_addr == tap_orient_pkg::TAP_THR_ADDR)
        tap_threshold_reg <= reg_wdata[tap_orient_pkg::TAP_THR_W-1:0];
      if (reg_addr == tap_orient_pkg::ORIENT_ADDR)
        orient_cfg_reg <= reg_wdata;
    end
  end

  // Read data, registered; other addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        tap_orient_pkg::TAP_THR_ADDR: reg_rdata <= {3'h0, tap_threshold_reg};
        tap_orient_pkg::ORIENT_ADDR: reg_rdata <= orient_cfg_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Millisecond tick; the period is a parameter so simulation can shorten it
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_reg <= 32'h0;
    end else if (div_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      div_cnt_reg <= 32'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 32'h1;
    end
  end
  assign ms_tick = (div_cnt_reg == 32'(TICK_CYCLES - 1));

  // ==========================================================
  // Tap threshold in 31.25 mg units: doubled code bits 3:0, or one when those bits are zero, shifted left by acc_range
  always_comb begin
    if (tap_threshold_reg[3:0] == 4'h0)
      thr_next = 8'h01 << acc_range;
    else
      thr_next = {3'h0, tap_threshold_reg[3:0], 1'b0} << acc_range;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tap_thr_eff <= 8'h01;
    end else begin
      tap_thr_eff <= thr_next;
    end
  end

  // Compared against the registered threshold, so a write takes effect a cycle late
  assign above = {4'h0, tap_thr_eff} < tap_slope;
  assign shock_rise = sample_valid & above & ~above_prev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      above_prev_reg <= 1'b0;
    end else if (sample_valid) begin
      above_prev_reg <= above;
    end
  end

  // ==========================================================
  // Tap period selections, read live
  assign quiet_ms = tap_quiet_sel ? tap_orient_pkg::QUIET_SHORT_MS
                                  : tap_orient_pkg::QUIET_LONG_MS;
  assign shock_ms = tap_shock_sel ? tap_orient_pkg::SHOCK_LONG_MS
                                  : tap_orient_pkg::SHOCK_SHORT_MS;
  assign win_ms = tap_orient_pkg::DTAP_WIN_MS[tap_dur_sel];

  // Tap sequencer; time is measured from the first shock
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= tap_orient_pkg::TAP_IDLE;
      elapsed_ms_reg <= 10'h000;
      single_tap_evt <= 1'b0;
      double_tap_evt <= 1'b0;
    end else begin
      single_tap_evt <= 1'b0;
      double_tap_evt <= 1'b0;
      if (ms_tick && elapsed_ms_reg != 10'h3FF)
        elapsed_ms_reg <= elapsed_ms_reg + 10'h001;
      case (state_reg)
        tap_orient_pkg::TAP_IDLE: begin
          if (shock_rise) begin
            state_reg <= tap_orient_pkg::TAP_SHOCK;
            elapsed_ms_reg <= 10'h000;
          end
        end
        tap_orient_pkg::TAP_SHOCK: begin
          if (elapsed_ms_reg >= win_ms) begin
            state_reg <= tap_orient_pkg::TAP_IDLE;
            single_tap_evt <= 1'b1;
          end else if (elapsed_ms_reg >= shock_ms) begin
            state_reg <= tap_orient_pkg::TAP_QUIET;
          end
        end
        tap_orient_pkg::TAP_QUIET: begin
          if (elapsed_ms_reg >= win_ms) begin
            state_reg <= tap_orient_pkg::TAP_IDLE;
            single_tap_evt <= 1'b1;
          end else if (elapsed_ms_reg >= shock_ms + quiet_ms) begin
            state_reg <= tap_orient_pkg::TAP_WINDOW;
          end
        end
        tap_orient_pkg::TAP_WINDOW: begin
          // Expiry wins over a shock in the same cycle: the window is closed
          if (elapsed_ms_reg >= win_ms) begin
            state_reg <= tap_orient_pkg::TAP_IDLE;
            single_tap_evt <= 1'b1;
          end else if (shock_rise) begin
            state_reg <= tap_orient_pkg::TAP_IDLE;
            double_tap_evt <= 1'b1;
          end
        end
        default: state_reg <= tap_orient_pkg::TAP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Low-power permission
  always_ff @(posedge clk) begin
    if (rst) begin
      low_power_en <= 1'b0;
    end else begin
      low_power_en <= lp_request & ~tap_prefilt_sel;
    end
  end

  // ==========================================================
  // Orientation settings
  always_ff @(posedge clk) begin
    if (rst) begin
      orient_hyst_half_mg <= 11'h000;
      orient_mode_sel <= 2'h0;
    end else begin
      // Both factors widened first, so code 15 (1875 half mg) is not cut
      orient_hyst_half_mg <= 11'(orient_cfg_reg[7:tap_orient_pkg::HYST_LSB])
                             * 11'(tap_orient_pkg::HYST_HALF_MG);
      orient_mode_sel <= orient_cfg_reg[tap_orient_pkg::MODE_LSB +: 2];
    end
  end

  orient_block u_orient (
    .clk(clk),
    .rst(rst),
    .ms_tick(ms_tick),
    .block_mode(orient_cfg_reg[tap_orient_pkg::BLOCK_LSB +: 2]),
    .sample_valid(sample_valid),
    .acc_x(acc_x),
    .acc_y(acc_y),
    .acc_z(acc_z),
    .slope_x(slope_x),
    .slope_y(slope_y),
    .slope_z(slope_z),
    .theta_block(theta_block),
    .orient_code(orient_code),
    .orient_blocked(orient_blocked),
    .orient_evt(orient_evt)
  );

  // ==========================================================
  // Checks
  property p_dbl_window;
    @(posedge clk) disable iff (rst)
    double_tap_evt |-> $past(elapsed_ms_reg) < $past(win_ms)
      && $past(elapsed_ms_reg) >= $past(shock_ms) + $past(quiet_ms);
  endproperty
  a_dbl_window: assert property (p_dbl_window) else $error("double tap outside window");

  property p_quiet_end;
    @(posedge clk) disable iff (rst)
    $rose(state_reg == tap_orient_pkg::TAP_WINDOW)
      |-> $past(elapsed_ms_reg) >= $past(shock_ms) + $past(quiet_ms);
  endproperty
  a_quiet_end: assert property (p_quiet_end) else $error("quiet period cut short");

  property p_shock_end;
    @(posedge clk) disable iff (rst)
    $rose(state_reg == tap_orient_pkg::TAP_QUIET) |-> $past(elapsed_ms_reg) >= $past(shock_ms);
  endproperty
  a_shock_end: assert property (p_shock_end) else $error("shock period cut short");

  property p_window_len;
    @(posedge clk) disable iff (rst)
    single_tap_evt |-> $past(elapsed_ms_reg) >= $past(win_ms);
  endproperty
  a_window_len: assert property (p_window_len) else $error("window closed early");

  property p_lp_block;
    @(posedge clk) disable iff (rst)
    tap_prefilt_sel |=> !low_power_en;
  endproperty
  a_lp_block: assert property (p_lp_block) else $error("low power with prefiltered tap");

  property p_thr_half;
    @(posedge clk) disable iff (rst)
    (tap_threshold_reg[3:0] == 4'h0 && acc_range == 2'h0) |=> tap_thr_eff == 8'h01;
  endproperty
  a_thr_half: assert property (p_thr_half) else $error("zero threshold not one half");

  property p_thr_scale;
    @(posedge clk) disable iff (rst)
    (tap_threshold_reg[3:0] != 4'h0 && acc_range == 2'h3)
      |=> tap_thr_eff == 8'($past(tap_threshold_reg[3:0]) * 16);
  endproperty
  a_thr_scale: assert property (p_thr_scale) else $error("16g threshold scale wrong");

  property p_hyst;
    @(posedge clk) disable iff (rst)
    (orient_cfg_reg[7:4] == 4'h1) |=> orient_hyst_half_mg == 11'h07D;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis step wrong");

  property p_mode;
    @(posedge clk) disable iff (rst)
    ##1 orient_mode_sel == $past(orient_cfg_reg[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode select stale");

  c_single: cover property (@(posedge clk) disable iff (rst) single_tap_evt);
  c_double: cover property (@(posedge clk) disable iff (rst) double_tap_evt);
  c_lp: cover property (@(posedge clk) disable iff (rst) low_power_en);
endmodule // tap_orient_interrupt_config

// file: test/host_model.sv
/*
  Host-side register master for the tap and orientation configuration block.
  Assumes the shared clock and the block's same-clock byte write port.
*/
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // ==========================================================
  // Bus idle at time zero, so nothing is written before reset ends
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One-cycle strobe; released at the next edge so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is registered, so it is taken two edges after the address moves
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    @(posedge clk);
    #1 d = reg_rdata;
  endtask
endmodule // host_model

// file: test/tap_orient_interrupt_config_tb_top.sv
/*
  Self-checking bench for the tap and orientation configuration block.
  Assumes host_model on the register port and a 4-cycle millisecond tick.
*/
`timescale 1ns/1ns
module tap_orient_interrupt_config_tb_top;
  // ==========================================================
  // Signals and tallies
  localparam int TK = 4;
  logic clk, rst, tap_quiet_sel, tap_shock_sel, tap_prefilt_sel, lp_request;
  logic sample_valid, theta_block, reg_wr, single_tap_evt, double_tap_evt;
  logic low_power_en, orient_blocked, orient_evt;
  logic [2:0] tap_dur_sel, orient_code;
  logic [1:0] acc_range, orient_mode_sel;
  logic [11:0] tap_slope;
  logic signed [15:0] acc_x, acc_y, acc_z;
  logic [15:0] slope_x, slope_y, slope_z;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tap_thr_eff, rd_val;
  logic [10:0] orient_hyst_half_mg;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n_single = 0, n_double = 0, n_orient = 0;
  int t_evt = 0;
  // ==========================================================
  // Block, host and clock
  tap_orient_interrupt_config #(.TICK_CYCLES(TK)) dut (.clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .tap_quiet_sel, .tap_shock_sel, .tap_dur_sel, .acc_range,
    .tap_prefilt_sel, .lp_request, .sample_valid, .tap_slope, .acc_x, .acc_y, .acc_z,
    .slope_x, .slope_y, .slope_z, .theta_block, .orient_code, .single_tap_evt,
    .double_tap_evt, .tap_thr_eff, .low_power_en, .orient_hyst_half_mg, .orient_mode_sel,
    .orient_blocked, .orient_evt);
  host_model host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses are tallied here, since tasks may be busy driving when they land
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (single_tap_evt === 1'b1) n_single <= n_single + 1;
    if (double_tap_evt === 1'b1) n_double <= n_double + 1;
    if (orient_evt === 1'b1) n_orient <= n_orient + 1;
    if (single_tap_evt === 1'b1 || double_tap_evt === 1'b1) t_evt <= cyc;
  end
  // ==========================================================
  // Shared helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One rise above threshold, then a quiet sample so the next rise is a new edge
  task automatic shock();
    @(posedge clk);
    sample_valid <= 1'b1;
    tap_slope <= 12'hFFF;
    @(posedge clk);
    tap_slope <= 12'h000;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    host.rd(8'h64, rd_val);
    check("thr reg", 16'h000A, rd_val);
    host.rd(8'h65, rd_val);
    check("orient reg", 16'h0018, rd_val);
    check("thr eff", 16'h0014, tap_thr_eff);
    check("hyst", 16'h007D, orient_hyst_half_mg);
    host.wr(8'h64, 8'hFF);
    host.wr(8'h66, 8'h55);
    host.rd(8'h64, rd_val);
    check("thr reg", 16'h001F, rd_val);
    host.rd(8'h66, rd_val);
    check("unmapped", 16'h0000, rd_val);
    host.wr(8'h65, 8'h3E);
    host.rd(8'h65, rd_val);
    check("orient reg", 16'h003E, rd_val);
    check("mode", 16'h0002, orient_mode_sel);
    check("hyst", 16'h0177, orient_hyst_half_mg);
    $display("register test done");
  endtask
  // Effective threshold in 31.25 mg steps: twice the code shifted left by the range, a zero code counts as half
  task automatic t_thr();
    int cl[4] = '{0, 1, 7, 15};
    for (int r = 0; r < 4; r++) begin
      foreach (cl[k]) begin
        host.wr(8'h64, 8'(cl[k]));
        acc_range <= 2'(r);
        settle(3);
        check("thr eff", 16'(((cl[k] == 0) ? 1 : 2 * cl[k]) << r), tap_thr_eff);
      end
    end
    for (int i = 0; i < 16; i++) begin
      host.wr(8'h65, 8'(i * 16 + i % 4));
      settle(2);
      check("hyst", 16'(i * 125), orient_hyst_half_mg);
      check("mode", 16'(i % 4), orient_mode_sel);
    end
    host.wr(8'h64, 8'h0A);
    acc_range <= 2'h0;
    $display("threshold test done");
  endtask
  task automatic t_lp();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      lp_request <= i[0];
      tap_prefilt_sel <= i[1];
      settle(2);
      check("low power", 16'(i[0] & ~i[1]), low_power_en);
    end
    $display("low power test done");
  endtask
  // First shock, optional second one gap ms later; win > 0 also times a single
  task automatic tap_run(input logic q, input logic s, input logic [2:0] d, input int gap,
                         input logic dbl, input int win);
    int t0, ns, nd, el;
    @(posedge clk);
    tap_quiet_sel <= q;
    tap_shock_sel <= s;
    tap_dur_sel <= d;
    ns = n_single;
    nd = n_double;
    t0 = cyc;
    shock();
    if (gap > 0) begin
      repeat (gap * TK - 2) @(posedge clk);
      shock();
    end
    for (int i = 0; i < 800 * TK && n_single + n_double == ns + nd; i++) @(posedge clk);
    settle(8);
    check("double", 16'(dbl), 16'(n_double - nd));
    check("single", 16'(!dbl), 16'(n_single - ns));
    el = t_evt - t0;
    if (win > 0) check("window", 16'h0001, 16'(el >= win * TK && el <= win * TK + 12));
  endtask
  task automatic t_tap();
    int wl[8] = '{50, 100, 150, 200, 250, 375, 500, 700};
    tap_run(1'b1, 1'b0, 3'h2, 75, 1'b1, 0);
    tap_run(1'b0, 1'b0, 3'h2, 75, 1'b0, 150);
    tap_run(1'b1, 1'b1, 3'h2, 85, 1'b0, 150);
    tap_run(1'b1, 1'b1, 3'h2, 100, 1'b1, 0);
    tap_run(1'b1, 1'b0, 3'h1, 96, 1'b1, 0);
    for (int d = 0; d < 8; d++) tap_run(1'b1, 1'b0, 3'(d), 0, 1'b0, wl[d]);
    $display("tap test done");
  endtask
  // One orientation sample with one axis loaded; blocking seen a cycle later
  task automatic osamp(input logic [2:0] code, input logic th, input int k, input int ax,
                       input int sl, input logic blk, input logic evt);
    int n0;
    n0 = n_orient;
    @(posedge clk);
    orient_code <= code;
    theta_block <= th;
    acc_x <= (k == 0) ? 16'(ax) : 16'h0000;
    acc_y <= (k == 1) ? 16'(ax) : 16'h0000;
    acc_z <= (k == 2) ? 16'(ax) : 16'h0000;
    slope_x <= (k == 0) ? 16'(sl) : 16'h0000;
    slope_y <= (k == 1) ? 16'(sl) : 16'h0000;
    slope_z <= (k == 2) ? 16'(sl) : 16'h0000;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    settle(2);
    check("blocked", 16'(blk), orient_blocked);
    check("orient evt", 16'(evt), 16'(n_orient - n0));
  endtask
  task automatic t_orient();
    host.wr(8'h65, 8'h00);
    osamp(3'h1, 1'b1, 0, 2000, 500, 1'b0, 1'b1);
    host.wr(8'h65, 8'h04);
    osamp(3'h2, 1'b1, 0, 0, 0, 1'b1, 1'b0);
    osamp(3'h2, 1'b0, 0, -1501, 0, 1'b1, 1'b0);
    osamp(3'h2, 1'b0, 1, 1500, 500, 1'b0, 1'b1);
    host.wr(8'h65, 8'h08);
    osamp(3'h3, 1'b0, 1, 0, 201, 1'b1, 1'b0);
    osamp(3'h3, 1'b0, 0, 0, 200, 1'b0, 1'b1);
    osamp(3'h1, 1'b0, 2, 1501, 0, 1'b1, 1'b0);
    host.wr(8'h65, 8'h0C);
    settle(110 * TK);
    osamp(3'h1, 1'b0, 2, 0, 300, 1'b0, 1'b1);
    osamp(3'h1, 1'b0, 2, 0, 401, 1'b1, 1'b0);
    osamp(3'h2, 1'b0, 0, 0, 0, 1'b1, 1'b0);
    settle(50 * TK);
    osamp(3'h2, 1'b0, 0, 0, 0, 1'b1, 1'b0);
    settle(60 * TK);
    osamp(3'h2, 1'b0, 0, 0, 0, 1'b0, 1'b1);
    $display("orientation test done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    {tap_quiet_sel, tap_shock_sel, tap_prefilt_sel, lp_request, sample_valid} = 5'h00;
    theta_block = 1'b0;
    tap_dur_sel = 3'h0;
    orient_code = 3'h0;
    acc_range = 2'h0;
    tap_slope = 12'h000;
    {acc_x, acc_y, acc_z, slope_x, slope_y, slope_z} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    t_regs();
    t_thr();
    t_lp();
    t_tap();
    t_orient();
    close_out();
  end
  // Whole run is near 13000 cycles; three times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule // tap_orient_interrupt_config_tb_top
